// ==== pidp.sv ====
// Constants, register map and types for the process frequency regulator.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
package pidp;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_DS = 100;
   localparam int TICKS_PER_S = 1000;
   localparam int PCT_FULL = 10000;
   localparam int GAIN_UNITY = 1000;
   // ----------------------------------------
   // Register word indices
   // ----------------------------------------
   localparam int NCFG = 24;
   localparam logic [4:0] A_KEYREF = 5'h00;
   localparam logic [4:0] A_REFSRC = 5'h01;
   localparam logic [4:0] A_FBSRC = 5'h02;
   localparam logic [4:0] A_PGAIN = 5'h03;
   localparam logic [4:0] A_PSCALE = 5'h04;
   localparam logic [4:0] A_ITIME = 5'h05;
   localparam logic [4:0] A_DTIME = 5'h06;
   localparam logic [4:0] A_FFGAIN = 5'h07;
   localparam logic [4:0] A_LPF = 5'h08;
   localparam logic [4:0] A_LIMHI = 5'h09;
   localparam logic [4:0] A_LIMLO = 5'h0a;
   localparam logic [4:0] A_OSCALE = 5'h0b;
   localparam logic [4:0] A_PREFREQ = 5'h0c;
   localparam logic [4:0] A_PREEXIT = 5'h0d;
   localparam logic [4:0] A_PRETO = 5'h0e;
   localparam logic [4:0] A_SLEEPDT = 5'h0f;
   localparam logic [4:0] A_SLEEPF = 5'h10;
   localparam logic [4:0] A_WAKELEV = 5'h11;
   localparam logic [4:0] A_WAKEMODE = 5'h12;
   localparam logic [4:0] A_USEL = 5'h13;
   localparam logic [4:0] A_UGAIN = 5'h14;
   localparam logic [4:0] A_USCALE = 5'h15;
   localparam logic [4:0] A_P2GAIN = 5'h16;
   localparam logic [4:0] A_MAXF = 5'h17;
   localparam logic [4:0] A_STATUS = 5'h18;
   localparam logic [4:0] A_DREF = 5'h19;
   localparam logic [4:0] A_DFB = 5'h1a;
   localparam logic [4:0] A_DOUT = 5'h1b;
   localparam logic [4:0] A_FREQ = 5'h1c;
   // ----------------------------------------
   // Reset values and legal maxima
   // ----------------------------------------
   localparam logic [15:0] CFG_RST [NCFG] = '{
      16'h1388, 16'h0000, 16'h0001, 16'h01f4, 16'h03e8, 16'h0064,
      16'h0000, 16'h0000, 16'h0000, 16'h1770, 16'h0032, 16'h03e8,
      16'h0000, 16'h0000, 16'h0258, 16'h0258, 16'h0000, 16'h0dac,
      16'h0000, 16'h0000, 16'h03e8, 16'h0002, 16'h03e8, 16'h1770};
   localparam logic [15:0] REFSRC_MAX = 16'h000b;
   localparam logic [15:0] FBSRC_MAX = 16'h000a;
   localparam logic [15:0] ITIME_MAX = 16'h07d0;
   localparam logic [15:0] USEL_MAX = 16'h000c;
   localparam logic [15:0] USCALE_MAX = 16'h0004;
   localparam logic [15:0] WAKE_MAX = 16'h0002;
   // ----------------------------------------
   // Status fields and types
   // ----------------------------------------
   localparam int ST_TRIP = 4;
   localparam int ST_BYPASS = 5;
   localparam int ST_GAIN2 = 6;
   typedef enum {ST_STOP, ST_PRE, ST_REG, ST_SLEEP, ST_FAIL} mode_e;
   typedef enum {C_IDLE, C_INT, C_LPF} calc_e;
endpackage : pidp

// ==== udiv32.sv ====
// Serial 32 by 32 unsigned divider, one quotient bit per clock.
// Assumes divisor below 2^31 and start only while idle.
`timescale 1ns/10ps
module udiv32 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [31:0] num_i,
   input wire logic [31:0] den_i,
   output logic done_o,
   output logic [31:0] quo_o
);
   logic [31:0] rem_ff;
   logic [31:0] den_ff;
   logic [5:0] cnt_ff;
   logic busy_ff;
   logic [32:0] trial;

   assign trial = {rem_ff, quo_o[31]} - {1'b0, den_ff};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rem_ff <= 32'h0;
         den_ff <= 32'h0;
         quo_o <= 32'h0;
         cnt_ff <= 6'h0;
         busy_ff <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i) begin
         rem_ff <= 32'h0;
         den_ff <= den_i;
         quo_o <= num_i;
         cnt_ff <= 6'h20;
         busy_ff <= 1'b1;
         done_o <= 1'b0;
      end else if (busy_ff) begin
         rem_ff <= trial[32] ? {rem_ff[30:0], quo_o[31]} : trial[31:0];
         quo_o <= {quo_o[30:0], ~trial[32]};
         cnt_ff <= cnt_ff - 6'h1;
         busy_ff <= (cnt_ff != 6'h1);
         done_o <= (cnt_ff == 6'h1);
      end else begin
         done_o <= 1'b0;
      end
   end
endmodule : udiv32

// ==== tick_timer.sv ====
// Counts control ticks while a condition holds; clears when it drops.
// Assumes tick_i is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
module tick_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic enable_i,
   input wire logic [23:0] limit_i,
   output logic expired_o
);
   logic [23:0] cnt_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         cnt_ff <= 24'h0;
      end else if (tick_i && cnt_ff < limit_i) begin
         cnt_ff <= cnt_ff + 24'h1;
      end
   end

   assign expired_o = enable_i && (cnt_ff >= limit_i);
endmodule : tick_timer

// ==== pid_freq_ctrl.sv ====
// Process regulator that produces the drive frequency command.
// Assumes a classic Wishbone master and pins from outside the clock domain.
`timescale 1ns/10ps
module pid_freq_ctrl #(
   parameter int TICK_CYCLES = pidp::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic run_i,
   input wire logic integral_clear_i,
   input wire logic second_gain_select_input_i,
   input wire logic regulation_bypass_input_i,
   input wire logic [15:0] reference_i,
   input wire logic [15:0] feedback_i,
   output logic [15:0] freq_cmd_o,
   output logic motor_enable_o,
   output logic prestart_failure_trip_o,
   output logic sleep_o
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [15:0] cfg_ff [pidp::NCFG];
   logic [3:0] pin_raw;
   logic [3:0] s1_ff;
   logic [3:0] s2_ff;
   logic [3:0] s3_ff;
   logic [3:0] pin_ff;
   logic run;
   logic iclear;
   logic gain2;
   logic bypass;
   logic [15:0] tick_cnt_ff;
   logic tick;
   pidp::mode_e mode_ff;
   pidp::calc_e calc_ff;
   logic ack_ff;
   logic acc_req;
   logic [4:0] widx;
   logic mapped;
   logic [15:0] wr_val;
   logic [31:0] rd_val;
   logic signed [31:0] ref_w;
   logic signed [31:0] fb_w;
   logic signed [31:0] err_w;
   logic signed [31:0] kp_w;
   logic signed [31:0] p_w;
   logic signed [31:0] d_w;
   logic signed [31:0] ff_w;
   logic signed [31:0] ilim_w;
   logic signed [31:0] acc_sum;
   logic signed [31:0] err_prev_ff;
   logic signed [31:0] acc_ff;
   logic signed [31:0] nxt_acc;
   logic signed [31:0] pd_ff;
   logic signed [31:0] i_w;
   logic signed [31:0] diff_w;
   logic signed [31:0] y_ff;
   logic signed [31:0] reg_hz;
   logic signed [31:0] byp_hz;
   logic signed [15:0] freq_ff;
   logic reg_active;
   logic div_start;
   logic [31:0] div_num;
   logic [31:0] div_den;
   logic div_done;
   logic [31:0] div_quo;
   logic diff_neg_ff;
   logic lpf_done;
   logic out_upd_ff;
   logic pre_expired;
   logic sleep_expired;
   logic wake;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic signed [31:0] sx(input logic [15:0] v);
      return $signed({{16{v[15]}}, v});
   endfunction : sx

   function automatic logic signed [31:0] ux(input logic [15:0] v);
      return $signed({16'h0, v});
   endfunction : ux

   function automatic logic signed [31:0] pct_to_hz(input logic signed [31:0] v);
      return (v * ux(cfg_ff[pidp::A_MAXF])) / pidp::PCT_FULL;
   endfunction : pct_to_hz

   function automatic logic [15:0] disp_val(input logic [15:0] v);
      logic signed [31:0] t;
      t = (sx(v) * ux(cfg_ff[pidp::A_UGAIN])) / pidp::GAIN_UNITY;
      case (cfg_ff[pidp::A_USCALE])
         16'h0000: t = t * 100;
         16'h0001: t = t * 10;
         16'h0003: t = t / 10;
         16'h0004: t = t / 100;
         default: t = t;
      endcase
      return t[15:0];
   endfunction : disp_val

   function automatic logic cfg_legal(input logic [4:0] idx, input logic [15:0] v);
      case (idx)
         pidp::A_REFSRC: return v <= pidp::REFSRC_MAX && v != cfg_ff[pidp::A_FBSRC];
         pidp::A_FBSRC: return v != 16'h0 && v <= pidp::FBSRC_MAX
            && v != cfg_ff[pidp::A_REFSRC];
         pidp::A_USEL: return v <= pidp::USEL_MAX;
         pidp::A_USCALE: return v <= pidp::USCALE_MAX;
         pidp::A_WAKEMODE: return v <= pidp::WAKE_MAX;
         pidp::A_ITIME: return v <= pidp::ITIME_MAX;
         pidp::A_OSCALE: return v != 16'h0;
         default: return 1'b1;
      endcase
   endfunction : cfg_legal

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign pin_raw = {regulation_bypass_input_i, second_gain_select_input_i,
                     integral_clear_i, run_i};

   genvar g;
   for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            s1_ff[g] <= 1'b0;
            s2_ff[g] <= 1'b0;
            s3_ff[g] <= 1'b0;
            pin_ff[g] <= 1'b0;
         end else begin
            s1_ff[g] <= pin_raw[g];
            s2_ff[g] <= s1_ff[g];
            s3_ff[g] <= s2_ff[g];
            if (s2_ff[g] == s3_ff[g]) begin
               pin_ff[g] <= s3_ff[g];
            end
         end
      end
   end

   assign run = pin_ff[0];
   assign iclear = pin_ff[1];
   assign gain2 = pin_ff[2];
   assign bypass = pin_ff[3];

   // ----------------------------------------
   // Control tick
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || tick) begin
         tick_cnt_ff <= 16'h0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 16'h1;
      end
   end

   assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   assign acc_req = cyc_i && stb_i && !ack_ff;
   assign widx = adr_i[6:2];
   assign mapped = !adr_i[7] && widx < 5'(pidp::NCFG);
   assign ack_o = ack_ff;

   always_comb begin
      wr_val = mapped ? cfg_ff[widx] : 16'h0;
      if (sel_i[0]) begin
         wr_val[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
         wr_val[15:8] = dat_i[15:8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < pidp::NCFG; i++) begin
            cfg_ff[i] <= pidp::CFG_RST[i];
         end
      end else if (acc_req && we_i && mapped && cfg_legal(widx, wr_val)) begin
         cfg_ff[widx] <= wr_val;
      end
   end

   always_comb begin
      rd_val = 32'h0;
      if (mapped) begin
         rd_val = {16'h0, cfg_ff[widx]};
      end else if (!adr_i[7]) begin
         case (widx)
            pidp::A_STATUS: begin
               rd_val[2:0] = 3'(mode_ff);
               rd_val[pidp::ST_TRIP] = prestart_failure_trip_o;
               rd_val[pidp::ST_BYPASS] = bypass;
               rd_val[pidp::ST_GAIN2] = gain2;
            end
            pidp::A_DREF: rd_val = sx(disp_val(ref_w[15:0]));
            pidp::A_DFB: rd_val = sx(disp_val(feedback_i));
            pidp::A_DOUT: rd_val = sx(disp_val(y_ff[15:0]));
            pidp::A_FREQ: rd_val = sx(freq_ff);
            default: rd_val = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_ff <= acc_req;
         if (acc_req && !we_i) begin
            dat_o <= rd_val;
         end
      end
   end

   // ----------------------------------------
   // Regulator terms
   // ----------------------------------------
   assign ref_w = (cfg_ff[pidp::A_REFSRC] == 16'h0) ? sx(cfg_ff[pidp::A_KEYREF])
                                                   : sx(reference_i);
   assign fb_w = sx(feedback_i);
   assign err_w = ref_w - fb_w;
   assign kp_w = gain2 ? ux(cfg_ff[pidp::A_P2GAIN]) : ux(cfg_ff[pidp::A_PGAIN]);
   assign p_w = ((err_w * kp_w) / pidp::GAIN_UNITY) * ux(cfg_ff[pidp::A_PSCALE])
                / pidp::GAIN_UNITY;
   assign d_w = (err_w - err_prev_ff) * ux(cfg_ff[pidp::A_DTIME]);
   assign ff_w = (ref_w * ux(cfg_ff[pidp::A_FFGAIN])) / pidp::GAIN_UNITY;
   assign ilim_w = ux(cfg_ff[pidp::A_ITIME]) * pidp::TICKS_PER_DS * pidp::PCT_FULL;
   assign acc_sum = acc_ff + err_w;
   assign reg_active = (mode_ff == pidp::ST_REG) && !bypass;

   always_comb begin
      nxt_acc = acc_sum;
      if (iclear) begin
         nxt_acc = 32'sh0;
      end else if (acc_sum > ilim_w) begin
         nxt_acc = ilim_w;
      end else if (acc_sum < -ilim_w) begin
         nxt_acc = -ilim_w;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || mode_ff != pidp::ST_REG || iclear) begin
         acc_ff <= 32'sh0;
      end else if (tick && reg_active) begin
         acc_ff <= nxt_acc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_prev_ff <= 32'sh0;
         pd_ff <= 32'sh0;
      end else if (tick && reg_active) begin
         err_prev_ff <= err_w;
         pd_ff <= p_w + d_w + ff_w;
      end
   end

   // ----------------------------------------
   // Integral divide and output filter
   // ----------------------------------------
   assign i_w = (cfg_ff[pidp::A_ITIME] == 16'h0 || iclear) ? 32'sh0
              : acc_ff[31] ? -$signed(div_quo) : $signed(div_quo);
   assign diff_w = pd_ff + i_w - y_ff;

   always_comb begin
      div_start = 1'b0;
      div_num = 32'h0;
      div_den = 32'h1;
      if (calc_ff == pidp::C_IDLE && tick && reg_active) begin
         div_start = 1'b1;
         div_num = nxt_acc[31] ? 32'(-nxt_acc) : 32'(nxt_acc);
         div_den = 32'(ux(cfg_ff[pidp::A_ITIME]) * pidp::TICKS_PER_DS);
         if (cfg_ff[pidp::A_ITIME] == 16'h0) begin
            div_den = 32'h1;
         end
      end else if (calc_ff == pidp::C_INT && div_done) begin
         div_start = 1'b1;
         div_num = diff_w[31] ? 32'(-diff_w) : 32'(diff_w);
         div_den = {16'h0, cfg_ff[pidp::A_LPF]} + 32'h1;
      end
   end

   udiv32 u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(div_start),
      .num_i(div_num),
      .den_i(div_den),
      .done_o(div_done),
      .quo_o(div_quo)
   );

   assign lpf_done = (calc_ff == pidp::C_LPF) && div_done;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         calc_ff <= pidp::C_IDLE;
         diff_neg_ff <= 1'b0;
         out_upd_ff <= 1'b0;
      end else begin
         out_upd_ff <= lpf_done;
         case (calc_ff)
            pidp::C_IDLE: if (div_start) begin
               calc_ff <= pidp::C_INT;
            end
            pidp::C_INT: if (div_done) begin
               calc_ff <= pidp::C_LPF;
               diff_neg_ff <= diff_w[31];
            end
            pidp::C_LPF: if (div_done) begin
               calc_ff <= pidp::C_IDLE;
            end
            default: calc_ff <= pidp::C_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || mode_ff != pidp::ST_REG) begin
         y_ff <= 32'sh0;
      end else if (lpf_done) begin
         y_ff <= diff_neg_ff ? y_ff - $signed(div_quo) : y_ff + $signed(div_quo);
      end
   end

   // ----------------------------------------
   // Frequency command
   // ----------------------------------------
   always_comb begin
      reg_hz = pct_to_hz((y_ff * ux(cfg_ff[pidp::A_OSCALE])) / pidp::GAIN_UNITY);
      if (reg_hz < 0) begin
         reg_hz = 32'sh0;
      end
      if (reg_hz > sx(cfg_ff[pidp::A_LIMHI])) begin
         reg_hz = sx(cfg_ff[pidp::A_LIMHI]);
      end
      if (reg_hz < sx(cfg_ff[pidp::A_LIMLO])) begin
         reg_hz = sx(cfg_ff[pidp::A_LIMLO]);
      end
      byp_hz = pct_to_hz(ref_w);
      if (byp_hz < 0) begin
         byp_hz = 32'sh0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_ff <= 16'sh0;
      end else begin
         case (mode_ff)
            pidp::ST_PRE: freq_ff <= $signed(cfg_ff[pidp::A_PREFREQ]);
            pidp::ST_REG: begin
               if (bypass) begin
                  freq_ff <= byp_hz[15:0];
               end else if (out_upd_ff) begin
                  freq_ff <= reg_hz[15:0];
               end
            end
            default: freq_ff <= 16'sh0;
         endcase
      end
   end

   assign freq_cmd_o = freq_ff;

   // ----------------------------------------
   // Prestart, sleep and wake
   // ----------------------------------------
   tick_timer u_pre_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .enable_i(mode_ff == pidp::ST_PRE),
      .limit_i(24'(ux(cfg_ff[pidp::A_PRETO]) * pidp::TICKS_PER_S)),
      .expired_o(pre_expired)
   );

   tick_timer u_sleep_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .enable_i(reg_active && freq_ff < $signed(cfg_ff[pidp::A_SLEEPF])),
      .limit_i(24'(ux(cfg_ff[pidp::A_SLEEPDT]) * pidp::TICKS_PER_DS)),
      .expired_o(sleep_expired)
   );

   always_comb begin
      case (cfg_ff[pidp::A_WAKEMODE])
         16'h0000: wake = fb_w < sx(cfg_ff[pidp::A_WAKELEV]);
         16'h0001: wake = fb_w > sx(cfg_ff[pidp::A_WAKELEV]);
         default: wake = err_w > sx(cfg_ff[pidp::A_WAKELEV]);
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= pidp::ST_STOP;
      end else if (tick) begin
         case (mode_ff)
            pidp::ST_STOP: if (run) begin
               mode_ff <= pidp::ST_PRE;
            end
            pidp::ST_PRE: begin
               if (!run) begin
                  mode_ff <= pidp::ST_STOP;
               end else if (fb_w > sx(cfg_ff[pidp::A_PREEXIT])) begin
                  mode_ff <= pidp::ST_REG;
               end else if (pre_expired) begin
                  mode_ff <= pidp::ST_FAIL;
               end
            end
            pidp::ST_REG: begin
               if (!run) begin
                  mode_ff <= pidp::ST_STOP;
               end else if (sleep_expired) begin
                  mode_ff <= pidp::ST_SLEEP;
               end
            end
            pidp::ST_SLEEP: begin
               if (!run) begin
                  mode_ff <= pidp::ST_STOP;
               end else if (wake) begin
                  mode_ff <= pidp::ST_REG;
               end
            end
            pidp::ST_FAIL: if (!run) begin
               mode_ff <= pidp::ST_STOP;
            end
            default: mode_ff <= pidp::ST_STOP;
         endcase
      end
   end

   assign motor_enable_o = (mode_ff == pidp::ST_PRE) || (mode_ff == pidp::ST_REG);
   assign prestart_failure_trip_o = (mode_ff == pidp::ST_FAIL);
   assign sleep_o = (mode_ff == pidp::ST_SLEEP);
endmodule : pid_freq_ctrl

// ==== pid_freq_ctrl_sva.sv ====
// Port assertions for the process frequency regulator.
// Assumes binding to pid_freq_ctrl and one clock domain.
`timescale 1ns/10ps
module pid_freq_ctrl_sva #(
   parameter int TICK_CYCLES = pidp::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [15:0] freq_cmd_o,
   input wire logic motor_enable_o,
   input wire logic prestart_failure_trip_o,
   input wire logic sleep_o
);
   // ---
   // Checks
   // ---
   logic [15:0] gap_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      if (rst_i || $changed(motor_enable_o)) gap_ff <= 16'h0000;
      else if (gap_ff != 16'hffff) gap_ff <= gap_ff + 16'h0001;
   end
   sequence taken_s; cyc_i && stb_i && !ack_o; endsequence
   sequence pulse_s; ack_o ##1 !ack_o; endsequence
   ack_answer_a: assert property (taken_s |=> pulse_s) else $error("ack not one cycle");
   read_hold_a: assert property (!(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o))
      else $error("read data moved");
   trip_cut_a: assert property (prestart_failure_trip_o |-> !motor_enable_o && !sleep_o)
      else $error("trip with drive on");
   sleep_stop_a: assert property (sleep_o |-> !motor_enable_o) else $error("sleep drives");
   stopped_zero_a: assert property (!motor_enable_o && !$past(motor_enable_o) |->
      freq_cmd_o == 16'h0000) else $error("command while stopped");
   no_reverse_a: assert property (motor_enable_o |-> !freq_cmd_o[15]) else $error("negative");
   mode_pace_a: assert property ($changed(motor_enable_o) |-> gap_ff >= TICK_CYCLES / 2)
      else $error("mode change off tick");
   reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
      freq_cmd_o == 16'h0000 && !motor_enable_o && !ack_o) else $error("reset not clear");
endmodule : pid_freq_ctrl_sva
bind pid_freq_ctrl pid_freq_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.clk_i(clk_i),
   .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
   .freq_cmd_o(freq_cmd_o), .motor_enable_o(motor_enable_o),
   .prestart_failure_trip_o(prestart_failure_trip_o), .sleep_o(sleep_o));

// ==== process_sensor.sv ====
// Process feedback sensor model.
// Assumes the bench sets the process level.
`timescale 1ns/10ps
module process_sensor (
   input wire logic clk_i,
   input wire logic [15:0] level_i,
   output logic [15:0] feedback_o
);
   always_ff @(posedge clk_i) begin
      feedback_o <= level_i;
   end
endmodule : process_sensor

// ==== process_pid_frequency_control_test.sv ====
// Self-checking bench for the process frequency regulator.
// Assumes the pidp package and a short control tick.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module process_pid_frequency_control_test;
   logic clk_i = 0, rst_i = 1, req = 0, we_i = 0, run_i = 0, gain2 = 0, byp = 0, iclr = 0;
   logic [7:0] adr_i = 0;
   logic [31:0] dat_i = 0, dat_o, rd;
   logic [15:0] reference_i = 0, level = 0, feedback_i, freq_cmd_o;
   logic ack_o, en, trip, sleep;
   int errors = 0, n_compared = 0;
   always #12.5 clk_i = ~clk_i;
   process_sensor sensor (.clk_i(clk_i), .level_i(level), .feedback_o(feedback_i));
   pid_freq_ctrl #(.TICK_CYCLES(100)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req),
      .stb_i(req), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .run_i(run_i), .integral_clear_i(iclr), .second_gain_select_input_i(gain2),
      .regulation_bypass_input_i(byp), .reference_i(reference_i), .feedback_i(feedback_i),
      .freq_cmd_o(freq_cmd_o), .motor_enable_o(en), .prestart_failure_trip_o(trip),
      .sleep_o(sleep));
   // ---
   // Shared tasks
   // ---
   task automatic give_verdict;
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic wb(input logic w, input logic [5:0] ix, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= 1'b1;
      we_i <= w;
      adr_i <= {ix, 2'b00};
      dat_i <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      req <= 1'b0;
      if (n >= 20) begin errors++; give_verdict(); end
   endtask : wb
   task automatic wr(input logic [4:0] ix, input logic [15:0] d);
      wb(1'b1, {1'b0, ix}, d);
   endtask : wr
   task automatic rdchk(input string nm, input logic [4:0] ix, input logic [15:0] e);
      wb(1'b0, {1'b0, ix}, 16'h0000);
      `CHK(nm, {16'h0000, e}, rd)
   endtask : rdchk
   task automatic mode(input logic [2:0] e);
      wb(1'b0, {1'b0, pidp::A_STATUS}, 16'h0000);
      `CHK("mode", e, rd[2:0])
   endtask : mode
   task automatic wait_freq(input logic [15:0] e);
      int n;
      n = 0;
      while (freq_cmd_o !== e && n < 3000) begin @(posedge clk_i); n++; end
      `CHK("freq_cmd", e, freq_cmd_o)
      if (freq_cmd_o !== e) give_verdict();
   endtask : wait_freq
   task automatic wait_for(input string nm, ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 15000) begin @(posedge clk_i); n++; end
      `CHK(nm, v, s)
      if (s !== v) give_verdict();
   endtask : wait_for
   // ---
   // Scenarios
   // ---
   task automatic t_regs;
      for (int i = 0; i < pidp::NCFG; i++) rdchk("rst val", 5'(i), pidp::CFG_RST[i]);
      wr(pidp::A_USEL, 16'h000d);
      rdchk("unit sel", pidp::A_USEL, 16'h0000);
      wr(pidp::A_USEL, 16'h000c);
      rdchk("unit sel", pidp::A_USEL, 16'h000c);
      wr(pidp::A_REFSRC, 16'h0001);
      rdchk("ref src", pidp::A_REFSRC, 16'h0000);
      wb(1'b0, 6'h20, 16'h0000);
      `CHK("unmapped", 32'h00000000, rd)
   endtask : t_regs
   task automatic t_run;
      wr(pidp::A_ITIME, 16'h0000);
      wr(pidp::A_PREFREQ, 16'h0bb8);
      wr(pidp::A_PREEXIT, 16'h07d0);
      run_i <= 1'b1;
      wait_freq(16'h0bb8);
      mode(3'h1);
      level <= 16'h09c4;
      wait_freq(16'h02ee);
      mode(3'h2);
      wr(pidp::A_USCALE, 16'h0001);
      rdchk("disp fb", pidp::A_DFB, 16'h61a8);
      byp <= 1'b1;
      wait_freq(16'h0bb8);
      wr(pidp::A_REFSRC, 16'h0002);
      reference_i <= 16'h1f40;
      wait_freq(16'h12c0);
      byp <= 1'b0;
      wait_freq(16'h0672);
   endtask : t_run
   task automatic t_gains;
      gain2 <= 1'b1;
      wait_freq(16'h0ce4);
      gain2 <= 1'b0;
      wr(pidp::A_PSCALE, 16'h01f4);
      wait_freq(16'h0339);
      wr(pidp::A_PSCALE, 16'h03e8);
      wr(pidp::A_OSCALE, 16'h05dc);
      wait_freq(16'h09ab);
      wr(pidp::A_LIMHI, 16'h03e8);
      wait_freq(16'h03e8);
   endtask : t_gains
   task automatic t_terms;
      iclr <= 1'b1;
      wr(pidp::A_LIMHI, 16'h1770);
      wr(pidp::A_LIMLO, 16'h0000);
      wr(pidp::A_OSCALE, 16'h03e8);
      wr(pidp::A_PGAIN, 16'h0000);
      wr(pidp::A_ITIME, 16'h0001);
      wait_freq(16'h0000);
      repeat (300) @(posedge clk_i);
      `CHK("held clear", 16'h0000, freq_cmd_o)
      iclr <= 1'b0;
      wait_freq(16'h014a);
      iclr <= 1'b1;
      wait_freq(16'h0000);
      wr(pidp::A_ITIME, 16'h0000);
      wr(pidp::A_LPF, 16'h0001);
      wr(pidp::A_FFGAIN, 16'h0064);
      wait_freq(16'h00f0);
      wait_freq(16'h0168);
      wr(pidp::A_LPF, 16'h0000);
      wait_freq(16'h01e0);
      wr(pidp::A_DTIME, 16'h0001);
      level <= 16'h07d0;
      wait_freq(16'h030c);
      wr(pidp::A_DTIME, 16'h0000);
      wr(pidp::A_FFGAIN, 16'h0000);
      wr(pidp::A_PGAIN, 16'h01f4);
      iclr <= 1'b0;
   endtask : t_terms
   task automatic t_sleep;
      wr(pidp::A_WAKEMODE, 16'h0001);
      wr(pidp::A_SLEEPDT, 16'h0001);
      wr(pidp::A_SLEEPF, 16'h07d0);
      wait_for("sleep", sleep, 1'b1);
      mode(3'h3);
      level <= 16'h0fa0;
      wait_for("sleep", sleep, 1'b0);
      wr(pidp::A_WAKEMODE, 16'h0002);
      wait_for("sleep", sleep, 1'b1);
      wait_for("sleep", sleep, 1'b0);
      level <= 16'h0bb8;
      wr(pidp::A_WAKEMODE, 16'h0000);
      wait_for("sleep", sleep, 1'b1);
      wait_for("sleep", sleep, 1'b0);
   endtask : t_sleep
   task automatic t_trip;
      run_i <= 1'b0;
      wait_for("enable", en, 1'b0);
      wr(pidp::A_PREEXIT, 16'h2328);
      wr(pidp::A_PRETO, 16'h0000);
      run_i <= 1'b1;
      wait_for("trip", trip, 1'b1);
      mode(3'h4);
      run_i <= 1'b0;
      wait_for("trip", trip, 1'b0);
   endtask : t_trip
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_run();
      t_gains();
      t_terms();
      t_sleep();
      t_trip();
      give_verdict();
   end
endmodule : process_pid_frequency_control_test
